//--- rtl/rdcfg_regs.sv
// Channel 1 and 2 configuration registers plus channel setting steering.
// Assumes the serial control slave presents single-cycle byte write and read
// strobes with an address; strap settings arrive already decoded per channel.
`timescale 1ns/1ps
module rdcfg_regs
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rhit_o,
  input wire rdcfg_pkg::rdcfg_glob_t glob_i,
  input wire rdcfg_pkg::rdcfg_chan_t [3:0] strap_i,
  input wire rdcfg_pkg::rdcfg_chan_t ch0_own_i,
  input wire rdcfg_pkg::rdcfg_chan_t ch3_own_i,
  output rdcfg_pkg::rdcfg_chan_t [3:0] chan_o
);

  logic [7:0] ch1_ctrl_q;
  logic [7:0] ch1_enab_q;
  logic [7:0] ch2_ctrl_q;
  logic [7:0] ch2_enab_q;
  rdcfg_pkg::rdcfg_chan_t ch1_reg;
  rdcfg_pkg::rdcfg_chan_t ch2_reg;
  rdcfg_pkg::rdcfg_chan_t [3:0] sel_d;
  rdcfg_pkg::rdcfg_chan_t [3:0] chan_q;
  logic [7:0] rdata_d;
  logic rhit_d;

  // Unpack a control and enable byte pair into channel settings
  function automatic rdcfg_pkg::rdcfg_chan_t unpack(input logic [7:0] ctrl, input logic [7:0] enab);
    rdcfg_pkg::rdcfg_chan_t c;
    c.equalizer_level = ctrl[rdcfg_pkg::EQ_LEVEL_LSB +: 3];
    c.tx_dc_gain = ctrl[rdcfg_pkg::TX_GAIN_POS];
    c.equalizer_flat_gain = ctrl[rdcfg_pkg::EQ_FLAT_POS];
    c.rx_gain = ctrl[rdcfg_pkg::RX_GAIN_LSB +: 2];
    c.driver_ac_boost = enab[rdcfg_pkg::AC_BOOST_POS];
    c.equalizer_stage_disable = enab[rdcfg_pkg::EQ_DIS_POS];
    c.output_stage_disable = enab[rdcfg_pkg::OUT_DIS_POS];
    return c;
  endfunction

  // Control registers store all eight bits, bit 7 included
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ch1_ctrl_q <= rdcfg_pkg::CTRL_RESET;
      ch2_ctrl_q <= rdcfg_pkg::CTRL_RESET;
    end
    else if (wr_en_i)
    begin
      if (addr_i == rdcfg_pkg::CH1_GAIN_CONTROL_ADDR)
        ch1_ctrl_q <= wdata_i;
      if (addr_i == rdcfg_pkg::CH2_GAIN_CONTROL_ADDR)
        ch2_ctrl_q <= wdata_i;
    end
  end

  // Enable registers keep only the low three bits; the rest cannot be set
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ch1_enab_q <= rdcfg_pkg::ENAB_RESET;
      ch2_enab_q <= rdcfg_pkg::ENAB_RESET;
    end
    else if (wr_en_i)
    begin
      if (addr_i == rdcfg_pkg::CH1_STAGE_ENABLES_ADDR)
        ch1_enab_q <= wdata_i & rdcfg_pkg::ENAB_WR_MASK;
      if (addr_i == rdcfg_pkg::CH2_STAGE_ENABLES_ADDR)
        ch2_enab_q <= wdata_i & rdcfg_pkg::ENAB_WR_MASK;
    end
  end

  // Read mux; unmapped addresses return zero and no hit
  always_comb
  begin
    rdata_d = 8'h00;
    rhit_d = 1'b1;
    case (addr_i)
      rdcfg_pkg::CH1_GAIN_CONTROL_ADDR: rdata_d = ch1_ctrl_q;
      rdcfg_pkg::CH1_STAGE_ENABLES_ADDR: rdata_d = ch1_enab_q;
      rdcfg_pkg::CH2_GAIN_CONTROL_ADDR: rdata_d = ch2_ctrl_q;
      rdcfg_pkg::CH2_STAGE_ENABLES_ADDR: rdata_d = ch2_enab_q;
      default: rhit_d = 1'b0;
    endcase
  end

  // Read data registered so the slave samples a stable byte
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
      rhit_o <= 1'b0;
    end
    else if (rd_en_i)
    begin
      rdata_o <= rdata_d;
      rhit_o <= rhit_d;
    end
  end

  assign ch1_reg = unpack(ch1_ctrl_q, ch1_enab_q);
  assign ch2_reg = unpack(ch2_ctrl_q, ch2_enab_q);

  // Steering: strap source wins, then all-track, then pair tracking
  always_comb
  begin
    sel_d = {ch3_own_i, ch2_reg, ch1_reg, ch0_own_i};
    if (glob_i.control_source_select)
      sel_d = strap_i;
    else if (!glob_i.no_track_all)
      sel_d = {ch1_reg, ch1_reg, ch1_reg, ch1_reg};
    else
    begin
      if (!glob_i.no_track_01)
        sel_d[0] = ch1_reg;
      if (!glob_i.no_track_23)
        sel_d[3] = ch2_reg;
    end
  end

  // Outputs registered; a write shows on the pins one cycle after storage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      chan_o <= '0;
    else
      chan_o <= sel_d;
  end
  assign chan_q = chan_o;

  // Reset leaves registers, read port and pins at zero
  AST_RESET_ZERO: assert property (@(posedge clk_i)
    !rst_n_i |=> ch1_ctrl_q == rdcfg_pkg::CTRL_RESET && ch2_ctrl_q == rdcfg_pkg::CTRL_RESET &&
    ch1_enab_q == rdcfg_pkg::ENAB_RESET && ch2_enab_q == rdcfg_pkg::ENAB_RESET &&
    chan_q == '0 && rdata_o == 8'h00 && !rhit_o)
    else $error("registers not cleared by reset");
  AST_ENAB_RO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ch1_enab_q[7:3] == 5'h00 && ch2_enab_q[7:3] == 5'h00)
    else $error("enable upper bits not zero");

  // Writes land in the addressed register only
  AST_CH1_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == rdcfg_pkg::CH1_GAIN_CONTROL_ADDR |=> ch1_ctrl_q == $past(wdata_i))
    else $error("channel 1 control write lost");
  AST_CH2_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == rdcfg_pkg::CH2_GAIN_CONTROL_ADDR |=> ch2_ctrl_q == $past(wdata_i))
    else $error("channel 2 control write lost");
  AST_CH1_ENAB_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == rdcfg_pkg::CH1_STAGE_ENABLES_ADDR |=>
    ch1_enab_q == ($past(wdata_i) & rdcfg_pkg::ENAB_WR_MASK))
    else $error("channel 1 enable write wrong");
  AST_CH2_ENAB_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == rdcfg_pkg::CH2_STAGE_ENABLES_ADDR |=>
    ch2_enab_q == ($past(wdata_i) & rdcfg_pkg::ENAB_WR_MASK))
    else $error("channel 2 enable write wrong");
  AST_CTRL_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_en_i && (addr_i == rdcfg_pkg::CH1_GAIN_CONTROL_ADDR ||
    addr_i == rdcfg_pkg::CH2_GAIN_CONTROL_ADDR)) |=> $stable(ch1_ctrl_q) && $stable(ch2_ctrl_q))
    else $error("control register changed without a write");
  AST_ENAB_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_en_i && (addr_i == rdcfg_pkg::CH1_STAGE_ENABLES_ADDR ||
    addr_i == rdcfg_pkg::CH2_STAGE_ENABLES_ADDR)) |=> $stable(ch1_enab_q) && $stable(ch2_enab_q))
    else $error("enable register changed without a write");

  // Read port returns the stored byte or zero with no hit
  AST_READ_CTRL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && addr_i == rdcfg_pkg::CH1_GAIN_CONTROL_ADDR |=> rdata_o == $past(ch1_ctrl_q) && rhit_o)
    else $error("channel 1 control read wrong");
  AST_READ_ENAB: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && addr_i == rdcfg_pkg::CH2_STAGE_ENABLES_ADDR |=> rdata_o == $past(ch2_enab_q) && rhit_o)
    else $error("channel 2 enable read wrong");
  AST_READ_MISS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && addr_i != rdcfg_pkg::CH1_GAIN_CONTROL_ADDR && addr_i != rdcfg_pkg::CH1_STAGE_ENABLES_ADDR &&
    addr_i != rdcfg_pkg::CH2_GAIN_CONTROL_ADDR && addr_i != rdcfg_pkg::CH2_STAGE_ENABLES_ADDR |=>
    rdata_o == 8'h00 && !rhit_o)
    else $error("unmapped read not empty");
  AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_en_i |=> $stable(rdata_o) && $stable(rhit_o))
    else $error("read data moved without a read");

  // Field placement on the pins under serial-bus control
  AST_EQ_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all |=> chan_q[1].equalizer_level == $past(ch1_ctrl_q[6:4]))
    else $error("channel 1 equalizer level wrong");
  AST_CTRL_FIELDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all |=>
    {chan_q[2].tx_dc_gain, chan_q[2].equalizer_flat_gain, chan_q[2].rx_gain} == $past(ch2_ctrl_q[3:0]))
    else $error("channel 2 gain fields wrong");
  AST_ENAB_FIELDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select |=> {chan_q[1].driver_ac_boost, chan_q[1].equalizer_stage_disable,
    chan_q[1].output_stage_disable} == $past(ch1_enab_q[2:0]))
    else $error("channel 1 stage bits wrong");
  AST_CH2_STAGES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all |=> {chan_q[2].driver_ac_boost,
    chan_q[2].equalizer_stage_disable, chan_q[2].output_stage_disable} == $past(ch2_enab_q[2:0]))
    else $error("channel 2 stage bits wrong");
  AST_WRITE_TO_PIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == rdcfg_pkg::CH1_STAGE_ENABLES_ADDR && !glob_i.control_source_select ##1 !wr_en_i |=>
    chan_q[1].output_stage_disable == $past(wdata_i[0], 2))
    else $error("write not on pins two cycles later");

  // Source selection and tracking priority
  AST_STRAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    glob_i.control_source_select |=> chan_q == $past(strap_i))
    else $error("strap source not applied");
  AST_TRACK_ALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && !glob_i.no_track_all |=>
    chan_q[0] == chan_q[1] && chan_q[2] == chan_q[1] && chan_q[3] == chan_q[1])
    else $error("all-channel tracking broken");
  AST_TRACK_01: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all && !glob_i.no_track_01 |=> chan_q[0] == chan_q[1])
    else $error("pair 0/1 tracking broken");
  AST_TRACK_23: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all && !glob_i.no_track_23 |=> chan_q[3] == chan_q[2])
    else $error("pair 2/3 tracking broken");
  AST_OWN_CH0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all && glob_i.no_track_01 |=>
    chan_q[0] == $past(ch0_own_i))
    else $error("channel 0 own settings not applied");
  AST_OWN_CH3: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all && glob_i.no_track_23 |=>
    chan_q[3] == $past(ch3_own_i))
    else $error("channel 3 own settings not applied");

  // Main scenarios worth seeing at least once
  COV_CH1_WRITE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == rdcfg_pkg::CH1_GAIN_CONTROL_ADDR);
  COV_CH2_READ: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && addr_i == rdcfg_pkg::CH2_STAGE_ENABLES_ADDR);
  COV_STRAP: cover property (@(posedge clk_i) disable iff (!rst_n_i) glob_i.control_source_select);
  COV_UNMAPPED: cover property (@(posedge clk_i) disable iff (!rst_n_i) rd_en_i && !rhit_d);
  COV_PAIR_TRACK: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !glob_i.control_source_select && glob_i.no_track_all && !glob_i.no_track_01 && !glob_i.no_track_23);

endmodule

//--- rtl/rdcfg_pkg.sv
// Package for the channel 1/2 configuration register bank of the redriver.
// Assumes a single clock domain; register access comes from the serial control
// port's internal byte bus. Global control bits and strap values arrive as ports.
// What this block does
// - Bits 6..4 of each control register hold the equalizer level, 000 weakest to 111 strongest.
// - Bit 3 of each control register selects transmitter DC gain, 0 for 0 dB and 1 for 6 dB.
// - Bit 2 of each control register selects equalizer flat gain, 0 for -6 dB and 1 for 0 dB.
// - Bits 1..0 of each control register select the receiver gain, 00 low, 01 mid, 11 high.
// - Bit 2 of each enable register turns on 6 dB of driver AC boost.
// - Bit 1 of each enable register disables the equalizer stage when high.
// - Bit 0 of each enable register disables the output driver stage when high.
// - Channel 1 control and enables sit at 0x05 and 0x06, channel 2 at 0x08 and 0x09, same layouts.
// - All four registers clear to zero on reset.
// - Enable register bits 7..3 are read-only zero; writable bits read back what was written.
// - Register settings apply only when the control source bit is 0; otherwise strap settings apply.
// - With the channel 0/1 pair-tracking bit at 0, channel 0 uses channel 1 settings.
// - With the channel 2/3 pair-tracking bit at 0, channel 3 uses channel 2 settings.
// - With the all-channel tracking bit at 0, every channel uses channel 1 settings, overriding pairs.
package rdcfg_pkg;

  localparam logic [7:0] CH1_GAIN_CONTROL_ADDR = 8'h05;
  localparam logic [7:0] CH1_STAGE_ENABLES_ADDR = 8'h06;
  localparam logic [7:0] CH2_GAIN_CONTROL_ADDR = 8'h08;
  localparam logic [7:0] CH2_STAGE_ENABLES_ADDR = 8'h09;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ENAB_RESET = 8'h00;
  localparam logic [7:0] ENAB_WR_MASK = 8'h07;

  localparam int RESERVED_BIT_POS = 7;
  localparam int EQ_LEVEL_LSB = 4;
  localparam int TX_GAIN_POS = 3;
  localparam int EQ_FLAT_POS = 2;
  localparam int RX_GAIN_LSB = 0;
  localparam int AC_BOOST_POS = 2;
  localparam int EQ_DIS_POS = 1;
  localparam int OUT_DIS_POS = 0;

  // Settings of one channel as seen by the analog datapath
  typedef struct packed {
    logic [2:0] equalizer_level;
    logic tx_dc_gain;
    logic equalizer_flat_gain;
    logic [1:0] rx_gain;
    logic driver_ac_boost;
    logic equalizer_stage_disable;
    logic output_stage_disable;
  } rdcfg_chan_t;

  // Global steering bits owned by the global control register
  typedef struct packed {
    logic control_source_select;
    logic no_track_01;
    logic no_track_23;
    logic no_track_all;
  } rdcfg_glob_t;

endpackage

//--- verification/rdcfg_host.sv
// Host model issuing byte writes and reads to the bank.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/1ps
module rdcfg_host
(
  input wire logic clk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus at time zero
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // One strobe held through its taking edge; released lines show inverted values
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr_en_o = w;
    rd_en_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

//--- verification/tb_redriver_channel_config_regs.sv
// Self-checking bench with a behavioural register and steering model.
// Assumes registered outputs: read data one edge, settings two edges after a strobe.
`timescale 1ns/1ps
module tb_redriver_channel_config_regs;
  logic clk_i;
  logic rst_n_i;
  logic wr_en, rd_en, rhit, w;
  logic [7:0] addr, wdata, rdata, d;
  rdcfg_pkg::rdcfg_glob_t glob = '0;
  rdcfg_pkg::rdcfg_chan_t [3:0] strap = '0;
  rdcfg_pkg::rdcfg_chan_t [3:0] chan;
  rdcfg_pkg::rdcfg_chan_t own0 = '0;
  rdcfg_pkg::rdcfg_chan_t own3 = '0;
  int err_count = 0;
  int n_checks = 0;
  int seed = 32'hb0ca;
  int k;
  logic [7:0] mreg [4];
  logic [7:0] amap [5] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h07};

  rdcfg_host u_host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  rdcfg_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .rhit_o(rhit), .glob_i(glob), .strap_i(strap), .ch0_own_i(own0),
    .ch3_own_i(own3), .chan_o(chan));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Model channel from its control and enable bytes
  function automatic rdcfg_pkg::rdcfg_chan_t own_of(int c);
    return {mreg[2*c][6:0], mreg[2*c+1][2:0]};
  endfunction

  // Steering priority: straps, all-track, then pair tracks
  function automatic rdcfg_pkg::rdcfg_chan_t [3:0] exp_ch();
    rdcfg_pkg::rdcfg_chan_t a, b;
    a = own_of(0);
    b = own_of(1);
    if (glob.control_source_select)
      return strap;
    if (!glob.no_track_all)
      return {a, a, a, a};
    return {glob.no_track_23 ? own3 : b, b, a, glob.no_track_01 ? own0 : a};
  endfunction

  task automatic chk_rd(input logic [8:0] exp);
    n_checks++;
    if ({rdata, rhit} !== exp)
    begin
      err_count++;
      $display("mismatch %0t read %h want %h", $time, {rdata, rhit}, exp);
    end
  endtask

  task automatic chk_ch(input logic [39:0] exp);
    n_checks++;
    if (chan !== exp)
    begin
      err_count++;
      $display("mismatch %0t settings %h want %h", $time, chan, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset also clears the model; outputs must read zero right after
  task automatic do_reset(input int n);
    rst_n_i = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    foreach (mreg[j]) mreg[j] = 8'h00;
    chk_rd(9'h000);
    chk_ch(40'h0);
  endtask

  // Hang guard, far beyond 300 two-cycle operations
  initial
  begin
    #(25 * 2000);
    err_count++;
    conclude();
  end

  // Random mix of mapped and unmapped accesses under random steering
  initial
  begin
    do_reset(2);
    for (int i = 0; i < 300; i++)
    begin
      if (i == 150)
        do_reset(1);
      k = $unsigned($random(seed)) % 5;
      w = 1'($random(seed));
      d = 8'($random(seed));
      glob = 4'($random(seed));
      strap = 40'({$random(seed), $random(seed)});
      own0 = 10'($random(seed));
      own3 = 10'($random(seed));
      u_host.acc(w, amap[k], d);
      if (w && k < 4)
        mreg[k] = k[0] ? (d & 8'h07) : d;
      if (!w)
        chk_rd(k < 4 ? {mreg[k], 1'b1} : 9'h000);
      @(posedge clk_i);
      #1;
      chk_ch(exp_ch());
    end
    conclude();
  end
endmodule
